// file: piezo_channel_control.sv
// Per-channel piezo control: APB registers, setpoint, jog, drive select and indicators
`timescale 1ns/1ps
`include "piezo_channel_defs.svh"
module piezo_channel_control #(
   parameter int unsigned IDENT_CYCLES = `IDENT_CYCLES
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // Analog side, already digitised
   input  wire logic [15:0] external_input_positive,
   input  wire logic [15:0] external_input_negative,
   input  wire logic [15:0] strain_gauge,
   input  wire logic [15:0] amp_voltage,
   // Fault inputs
   input  wire logic        supply_fault,
   input  wire logic        actuator_present,
   input  wire logic        over_temp,
   // Amplifier and loop outputs
   output logic [15:0]      high_voltage_amplifier,
   output logic [15:0]      position_target,
   output logic             loop_closed,
   output logic [7:0]       loop_proportional,
   output logic [7:0]       loop_integral,
   // Indicators
   output logic             enable_led,
   output logic             active_led,
   output logic             error_led,
   output logic             ident_led,
   output logic             closed_loop_led,
   output logic             open_loop_led,
   output logic             volts_led,
   output logic             position_led
);

   piezo_channel_pkg::control_type     control_reg;
   piezo_channel_pkg::gain_type        gain_reg;
   piezo_channel_pkg::force_type       force_reg;
   piezo_channel_pkg::ident_state_type ident_state_reg;
   logic [15:0] setpoint_reg;
   logic [15:0] setpoint_next;
   logic [15:0] jog_step_reg;
   logic [15:0] zero_offset_reg;
   logic [31:0] ident_count_reg;
   logic [31:0] readout_reg;
   logic [31:0] read_next;
   logic [16:0] jog_sum;
   logic [17:0] drive_sum;
   logic [16:0] position_diff;
   logic [16:0] force_diff;
   logic [15:0] position_um;
   logic [15:0] force_raw;
   logic [31:0] force_scaled;
   logic        wr_en;
   logic        cmd_wr;
   logic        addr_ok;
   logic        fault;

   // Every access completes in one access cycle
   assign pready  = 1'b1;
   assign wr_en   = psel & penable & pwrite;
   assign cmd_wr  = wr_en && paddr == `OFF_COMMAND;
   assign addr_ok = paddr[1:0] == 2'b00 && paddr <= `OFF_READOUT;
   assign pslverr = psel & penable & ~addr_ok;

   // Settings; toggles and writes share one flop so a toggle lands on the written value
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         control_reg <= '0;
         gain_reg    <= {`RST_GAIN, `RST_GAIN};
         force_reg   <= {16'h0000, `RST_FORCE_CAL};
         jog_step_reg <= `RST_JOG_STEP;
      end else if (wr_en) begin
         case (paddr)
            `OFF_CONTROL:   control_reg  <= piezo_channel_pkg::control_type'(pwdata[4:0]);
            `OFF_JOG_STEP:  jog_step_reg <= pwdata[15:0];
            `OFF_LOOP_GAIN: gain_reg     <= pwdata[15:0];
            `OFF_FORCE:     force_reg    <= pwdata;
            `OFF_COMMAND: begin
               if (pwdata[`CMD_TOG_LOOP])
                  control_reg.closed_loop <= ~control_reg.closed_loop;
               if (pwdata[`CMD_TOG_DISP])
                  control_reg.display_position <= ~control_reg.display_position;
            end
            default: ;
         endcase
      end
   end

   // Jog arithmetic: one step per command, clamped at both ends
   assign jog_sum = {1'b0, setpoint_reg} + {1'b0, jog_step_reg};
   always_comb begin
      setpoint_next = setpoint_reg;
      if (wr_en && paddr == `OFF_SETPOINT)
         setpoint_next = pwdata[15:0];
      else if (cmd_wr && pwdata[`CMD_JOG_UP] && !pwdata[`CMD_JOG_DOWN])
         setpoint_next = jog_sum[16] ? `SETPOINT_MAX : jog_sum[15:0];
      else if (cmd_wr && pwdata[`CMD_JOG_DOWN] && !pwdata[`CMD_JOG_UP])
         setpoint_next = setpoint_reg > jog_step_reg ?
                         setpoint_reg - jog_step_reg : 16'h0000;
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst)
         setpoint_reg <= 16'h0000;
      else
         setpoint_reg <= setpoint_next;
   end

   // Zero captures the raw gauge reading
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst)
         zero_offset_reg <= 16'h0000;
      else if (cmd_wr && pwdata[`CMD_ZERO])
         zero_offset_reg <= strain_gauge;
   end

   // Identify flash timer; a new request restarts the period
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ident_state_reg <= piezo_channel_pkg::ident_idle;
         ident_count_reg <= 32'h00000000;
      end else if (cmd_wr && pwdata[`CMD_IDENT]) begin
         ident_state_reg <= piezo_channel_pkg::ident_flash;
         ident_count_reg <= 32'h00000000;
      end else begin
         case (ident_state_reg)
            piezo_channel_pkg::ident_idle: ident_count_reg <= 32'h00000000;
            piezo_channel_pkg::ident_flash: begin
               // Count wraps to zero on the last cycle so it never passes the period
               if (ident_count_reg >= IDENT_CYCLES - 1) begin
                  ident_state_reg <= piezo_channel_pkg::ident_idle;
                  ident_count_reg <= 32'h00000000;
               end else begin
                  ident_count_reg <= ident_count_reg + 32'h00000001;
               end
            end
            default: ident_state_reg <= piezo_channel_pkg::ident_idle;
         endcase
      end
   end

   // Drive: source select, sum saturates rather than wrapping
   assign drive_sum = control_reg.source == piezo_channel_pkg::external_plus_software_source ?
                      {2'b00, setpoint_reg} + {2'b00, external_input_positive}
                      - {2'b00, external_input_negative} :
                      {2'b00, setpoint_reg};
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         high_voltage_amplifier <= 16'h0000;
         position_target        <= 16'h0000;
      end else if (!control_reg.enable) begin
         high_voltage_amplifier <= 16'h0000;
         position_target        <= 16'h0000;
      end else if (control_reg.closed_loop) begin
         // Amplifier voltage is set by the external servo from position_target
         position_target        <= setpoint_reg;
         high_voltage_amplifier <= amp_voltage;
      end else begin
         position_target        <= 16'h0000;
         // Negative sums floor at zero, overflow holds at full scale
         high_voltage_amplifier <= drive_sum[17] ? 16'h0000 :
                                   drive_sum[16] ? `SETPOINT_MAX : drive_sum[15:0];
      end
   end

   // Readout in the unit the display selects
   assign position_diff = {1'b0, strain_gauge} - {1'b0, zero_offset_reg};
   assign position_um   = position_diff[16] ? 16'h0000 : position_diff[15:0];
   assign force_diff    = {1'b0, strain_gauge} - {1'b0, force_reg.offset};
   assign force_raw     = force_diff[16] ? 16'h0000 : force_diff[15:0];
   // Force is the offset-corrected gauge count times the calibration value
   assign force_scaled  = force_raw * force_reg.calibration;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst)
         readout_reg <= 32'h00000000;
      else if (!control_reg.display_position)
         readout_reg <= {16'h0000, high_voltage_amplifier};
      else if (control_reg.force_mode)
         readout_reg <= force_scaled;
      else
         readout_reg <= {16'h0000, position_um};
   end

   // Indicators
   assign fault = supply_fault | over_temp | (control_reg.closed_loop & ~actuator_present);
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         error_led  <= 1'b0;
         active_led <= 1'b0;
         ident_led  <= 1'b0;
      end else begin
         error_led  <= fault;
         active_led <= ~fault;
         ident_led  <= ident_state_reg == piezo_channel_pkg::ident_flash &&
                       ident_count_reg[`BLINK_BIT];
      end
   end
   assign enable_led        = control_reg.enable;
   assign closed_loop_led   = control_reg.closed_loop;
   assign open_loop_led     = ~control_reg.closed_loop;
   assign position_led      = control_reg.display_position;
   assign volts_led         = ~control_reg.display_position;
   assign loop_closed       = control_reg.closed_loop & control_reg.enable;
   assign loop_proportional = gain_reg.proportional;
   assign loop_integral     = gain_reg.integral;

   // Read mux, registered
   always_comb begin
      read_next = 32'h00000000;
      case (paddr)
         `OFF_CONTROL:   read_next = {27'h0000000, control_reg};
         `OFF_SETPOINT:  read_next = {16'h0000, setpoint_reg};
         `OFF_JOG_STEP:  read_next = {16'h0000, jog_step_reg};
         `OFF_LOOP_GAIN: read_next = {16'h0000, gain_reg};
         `OFF_FORCE:     read_next = force_reg;
         `OFF_STATUS:    read_next = {28'h0000000,
                                      ident_state_reg == piezo_channel_pkg::ident_flash,
                                      fault, ~fault, control_reg.enable};
         `OFF_READOUT:   read_next = readout_reg;
         default:        read_next = 32'h00000000;
      endcase
   end
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst)
         prdata <= 32'h00000000;
      else if (psel & ~penable & ~pwrite)
         prdata <= read_next;
   end

   // Checks; expectations are rebuilt from inputs, not from the internal sums
   sequence open_drive_seq;
      control_reg.enable && !control_reg.closed_loop;
   endsequence
   sequence closed_drive_seq;
      control_reg.enable && control_reg.closed_loop;
   endsequence
   sequence jog_up_seq;
      cmd_wr && pwdata[1:0] == 2'b01;
   endsequence
   sequence jog_down_seq;
      cmd_wr && pwdata[1:0] == 2'b10;
   endsequence
   sequence position_view_seq;
      control_reg.display_position && !control_reg.force_mode;
   endsequence
   sequence ident_start_seq;
      cmd_wr && pwdata[`CMD_IDENT];
   endsequence

   chk_jog_up_step: assert property (@(posedge mclk) disable iff (sys_rst)
      jog_up_seq ##0 !jog_sum[16] |=> setpoint_reg == $past(setpoint_reg + jog_step_reg))
      else $error("jog up did not add one step");
   chk_jog_up_clamp: assert property (@(posedge mclk) disable iff (sys_rst)
      jog_up_seq ##0 jog_sum[16] |=> setpoint_reg == `SETPOINT_MAX)
      else $error("jog up did not clamp at full scale");
   chk_jog_down_step: assert property (@(posedge mclk) disable iff (sys_rst)
      jog_down_seq ##0 setpoint_reg > jog_step_reg |=> setpoint_reg == $past(setpoint_reg - jog_step_reg))
      else $error("jog down did not remove one step");
   chk_jog_down_clamp: assert property (@(posedge mclk) disable iff (sys_rst)
      jog_down_seq ##0 setpoint_reg <= jog_step_reg |=> setpoint_reg == 16'h0000)
      else $error("jog down did not clamp at zero");
   chk_jog_both_hold: assert property (@(posedge mclk) disable iff (sys_rst)
      cmd_wr && pwdata[1:0] == 2'b11 |=> $stable(setpoint_reg))
      else $error("conflicting jog moved the setpoint");
   chk_setpoint_write: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_en && paddr == `OFF_SETPOINT |=> setpoint_reg == $past(pwdata[15:0]))
      else $error("setpoint write lost");

   chk_disable_zero: assert property (@(posedge mclk) disable iff (sys_rst)
      !control_reg.enable |=> high_voltage_amplifier == 16'h0000 && position_target == 16'h0000)
      else $error("disabled channel drives amplifier");
   chk_software_drive: assert property (@(posedge mclk) disable iff (sys_rst)
      open_drive_seq ##0 control_reg.source == piezo_channel_pkg::software_only_source
      |=> high_voltage_amplifier == $past(setpoint_reg))
      else $error("software-only drive mismatch");
   chk_external_sum: assert property (@(posedge mclk) disable iff (sys_rst)
      open_drive_seq ##0 control_reg.source == piezo_channel_pkg::external_plus_software_source
      ##0 drive_sum[17:16] == 2'b00
      |=> high_voltage_amplifier ==
          $past(setpoint_reg + external_input_positive - external_input_negative))
      else $error("external plus software drive mismatch");
   chk_external_floor: assert property (@(posedge mclk) disable iff (sys_rst)
      open_drive_seq ##0 drive_sum[17] |=> high_voltage_amplifier == 16'h0000)
      else $error("negative drive not floored");
   chk_open_target: assert property (@(posedge mclk) disable iff (sys_rst)
      open_drive_seq |=> position_target == 16'h0000)
      else $error("open loop drives a position target");
   chk_closed_target: assert property (@(posedge mclk) disable iff (sys_rst)
      closed_drive_seq |=> position_target == $past(setpoint_reg))
      else $error("closed loop target mismatch");
   chk_closed_amp: assert property (@(posedge mclk) disable iff (sys_rst)
      closed_drive_seq |=> high_voltage_amplifier == $past(amp_voltage))
      else $error("closed loop amplifier not from servo");

   chk_readout_volts: assert property (@(posedge mclk) disable iff (sys_rst)
      !control_reg.display_position |=> readout_reg == {16'h0000, $past(high_voltage_amplifier)})
      else $error("volts readout mismatch");
   chk_readout_position: assert property (@(posedge mclk) disable iff (sys_rst)
      position_view_seq ##0 strain_gauge >= zero_offset_reg
      |=> readout_reg == {16'h0000, $past(strain_gauge - zero_offset_reg)})
      else $error("position readout mismatch");
   chk_position_floor: assert property (@(posedge mclk) disable iff (sys_rst)
      position_view_seq ##0 strain_gauge < zero_offset_reg |=> readout_reg == 32'h00000000)
      else $error("position below zero not floored");
   chk_force_readout: assert property (@(posedge mclk) disable iff (sys_rst)
      control_reg.display_position && control_reg.force_mode && strain_gauge >= force_reg.offset
      |=> readout_reg == $past({16'h0000, strain_gauge - force_reg.offset}) *
                         $past({16'h0000, force_reg.calibration}))
      else $error("force readout mismatch");
   chk_zero_capture: assert property (@(posedge mclk) disable iff (sys_rst)
      cmd_wr && pwdata[`CMD_ZERO] |=> zero_offset_reg == $past(strain_gauge))
      else $error("zero offset not captured");

   chk_error_fault: assert property (@(posedge mclk) disable iff (sys_rst)
      over_temp || supply_fault |=> error_led && !active_led)
      else $error("fault not flagged");
   chk_missing_actuator: assert property (@(posedge mclk) disable iff (sys_rst)
      control_reg.closed_loop && !actuator_present |=> error_led)
      else $error("missing actuator not flagged");
   chk_active_normal: assert property (@(posedge mclk) disable iff (sys_rst)
      !supply_fault && !over_temp && (actuator_present || !control_reg.closed_loop)
      |=> active_led && !error_led)
      else $error("active indicator wrong in normal operation");
   chk_loop_toggle: assert property (@(posedge mclk) disable iff (sys_rst)
      cmd_wr && pwdata[`CMD_TOG_LOOP]
      |=> control_reg.closed_loop != $past(control_reg.closed_loop))
      else $error("loop mode did not toggle");
   chk_display_toggle: assert property (@(posedge mclk) disable iff (sys_rst)
      cmd_wr && pwdata[`CMD_TOG_DISP]
      |=> control_reg.display_position != $past(control_reg.display_position))
      else $error("display mode did not toggle");
   chk_gain_write: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_en && paddr == `OFF_LOOP_GAIN
      |=> {loop_integral, loop_proportional} == $past(pwdata[15:0]))
      else $error("loop constants not stored");

   chk_ident_start: assert property (@(posedge mclk) disable iff (sys_rst)
      ident_start_seq |=> ident_state_reg == piezo_channel_pkg::ident_flash)
      else $error("identify did not start");
   chk_ident_end: assert property (@(posedge mclk) disable iff (sys_rst)
      ident_state_reg == piezo_channel_pkg::ident_flash && ident_count_reg == IDENT_CYCLES - 1
      && !(cmd_wr && pwdata[`CMD_IDENT]) |=> ident_state_reg == piezo_channel_pkg::ident_idle)
      else $error("identify did not stop");
   chk_ident_bound: assert property (@(posedge mclk) disable iff (sys_rst)
      ident_count_reg < IDENT_CYCLES)
      else $error("identify ran past its period");
   chk_force_reset: assert property (@(posedge mclk)
      $fell(sys_rst) |-> force_reg.calibration == `RST_FORCE_CAL)
      else $error("force calibration reset wrong");

endmodule // piezo_channel_control

// file: piezo_channel_defs.svh
// Register offsets, field positions, reset values and timing counts for the piezo channel
`ifndef PIEZO_CHANNEL_DEFS_SVH
`define PIEZO_CHANNEL_DEFS_SVH
`define OFF_CONTROL      12'h000
`define OFF_SETPOINT     12'h004
`define OFF_JOG_STEP     12'h008
`define OFF_LOOP_GAIN    12'h00c
`define OFF_FORCE        12'h010
`define OFF_COMMAND      12'h014
`define OFF_STATUS       12'h018
`define OFF_READOUT      12'h01c
`define CTL_ENABLE       0
`define CTL_CLOSED       1
`define CTL_DISP_POS     2
`define CTL_EXT_SRC      3
`define CTL_FORCE        4
`define CMD_JOG_UP       0
`define CMD_JOG_DOWN     1
`define CMD_ZERO         2
`define CMD_IDENT        3
`define CMD_TOG_LOOP     4
`define CMD_TOG_DISP     5
`define ST_ENABLED       0
`define ST_ACTIVE        1
`define ST_ERROR         2
`define ST_IDENT         3
`define RST_GAIN         8'h64
`define RST_FORCE_CAL    16'h001e
`define RST_JOG_STEP     16'h0001
`define SETPOINT_MAX     16'hffff
`define IDENT_TIME_MS    500
`define IDENT_CYCLES     ((`IDENT_TIME_MS) * 100000)
`define BLINK_BIT        22
`endif

// file: piezo_channel_pkg.sv
// Types for the piezo channel control block
package piezo_channel_pkg;
   typedef enum logic {software_only_source, external_plus_software_source} source_type;
   typedef struct packed {
      logic        force_mode;
      source_type  source;
      logic        display_position;
      logic        closed_loop;
      logic        enable;
   } control_type;
   typedef struct packed {
      logic [7:0] integral;
      logic [7:0] proportional;
   } gain_type;
   typedef struct packed {
      logic [15:0] offset;
      logic [15:0] calibration;
   } force_type;
   typedef enum {ident_idle, ident_flash} ident_state_type;
endpackage

// file: piezo_actuator_model.sv
// Behavioural piezo actuator with strain gauge and ideal servo
`timescale 1ns/1ps
module piezo_actuator_model #(
   parameter logic [15:0] GAUGE_OFFSET = 16'h0040
) (
   // Clock
   input  wire logic        mclk,
   // Bench control
   input  wire logic        connected,
   // From the channel
   input  wire logic [15:0] drive,
   input  wire logic [15:0] target,
   input  wire logic        closed,
   // Sensor and servo
   output logic [15:0]      strain_gauge,
   output logic [15:0]      amp_voltage,
   output logic             actuator_present
);
   assign actuator_present = connected;
   // An unplugged gauge floats, so the code moves every cycle
   always_ff @(posedge mclk) begin
      if (connected) begin
         strain_gauge <= GAUGE_OFFSET + (drive >> 4);
      end else begin
         strain_gauge <= ~strain_gauge;
      end
   end
   // Servo settles on the target in one cycle; slower settling is not modelled
   always_ff @(posedge mclk) begin
      amp_voltage <= closed ? target : 16'h0000;
   end
endmodule // piezo_actuator_model

// file: test_piezo_channel_control.sv
// Self-checking bench for the piezo channel control block
`timescale 1ns/1ps
`include "piezo_channel_defs.svh"
module test_piezo_channel_control;
   logic        mclk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        pready, pslverr, loop_closed, present, err;
   logic [31:0] prdata, rd;
   logic [15:0] ext_p = 16'h0000;
   logic [15:0] ext_n = 16'h0000;
   logic [15:0] gauge, amp_v, hva, target;
   logic        sup_f = 1'b0;
   logic        otemp = 1'b0;
   logic        connected = 1'b1;
   logic [7:0]  kp, ki;
   logic        en_led, act_led, err_led, id_led, cl_led, ol_led, v_led, p_led;
   int          n_errors = 0;
   int          check_count = 0;
   int          cycles = 0;

   always #5 mclk = ~mclk;

   piezo_channel_control #(.IDENT_CYCLES(64)) i_dut (
      .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .external_input_positive(ext_p), .external_input_negative(ext_n),
      .strain_gauge(gauge), .amp_voltage(amp_v), .supply_fault(sup_f),
      .actuator_present(present), .over_temp(otemp), .high_voltage_amplifier(hva),
      .position_target(target), .loop_closed(loop_closed), .loop_proportional(kp),
      .loop_integral(ki), .enable_led(en_led), .active_led(act_led), .error_led(err_led),
      .ident_led(id_led), .closed_loop_led(cl_led), .open_loop_led(ol_led),
      .volts_led(v_led), .position_led(p_led));

   piezo_actuator_model i_act (
      .mclk(mclk), .connected(connected), .drive(hva), .target(target),
      .closed(loop_closed), .strain_gauge(gauge), .amp_voltage(amp_v),
      .actuator_present(present));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Setup cycle, then access held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask

   task automatic settle();
      repeat (4) @(posedge mclk);
   endtask

   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         report_and_stop();
      end
   end

   initial begin
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      // Defaults after reset
      rdchk(`OFF_CONTROL, 32'h0);
      rdchk(`OFF_JOG_STEP, 32'h1);
      rdchk(`OFF_LOOP_GAIN, 32'h6464);
      rdchk(`OFF_FORCE, 32'h1e);
      check(ol_led & v_led, 1'b1);
      // Open loop drive, both sources, then disable
      wr(`OFF_CONTROL, 32'h1);
      wr(`OFF_SETPOINT, 32'h1234);
      ext_p <= 16'h0100;
      ext_n <= 16'h0040;
      settle();
      check(hva, 16'h1234);
      check({loop_closed, en_led}, 2'b01);
      wr(`OFF_CONTROL, 32'h9);
      settle();
      check(hva, 16'h12f4);
      rdchk(`OFF_READOUT, 32'h12f4);
      wr(`OFF_CONTROL, 32'h0);
      settle();
      check({hva, en_led}, 17'h0);
      // Closed loop position command, gains, jog in microns
      wr(`OFF_CONTROL, 32'h3);
      wr(`OFF_SETPOINT, 32'h2000);
      wr(`OFF_LOOP_GAIN, 32'h12ff);
      settle();
      check({loop_closed, target}, 17'h12000);
      check(hva, 16'h2000);
      check({ki, kp}, 16'h12ff);
      rdchk(`OFF_READOUT, 32'h2000);
      wr(`OFF_JOG_STEP, 32'h10);
      wr(`OFF_COMMAND, 32'h1);
      settle();
      check(target, 16'h2010);
      // Open loop jog, clamps at both ends
      wr(`OFF_CONTROL, 32'h1);
      wr(`OFF_SETPOINT, 32'h8);
      wr(`OFF_COMMAND, 32'h2);
      rdchk(`OFF_SETPOINT, 32'h0);
      wr(`OFF_COMMAND, 32'h1);
      wr(`OFF_COMMAND, 32'h1);
      rdchk(`OFF_SETPOINT, 32'h20);
      wr(`OFF_COMMAND, 32'h3);
      rdchk(`OFF_SETPOINT, 32'h20);
      wr(`OFF_SETPOINT, 32'hfff8);
      wr(`OFF_COMMAND, 32'h1);
      rdchk(`OFF_SETPOINT, 32'hffff);
      ext_p <= 16'h0000;
      ext_n <= 16'h0000;
      settle();
      check(hva, 16'hffff);
      // Fault sources one by one
      check({act_led, err_led}, 2'b10);
      sup_f <= 1'b1;
      settle();
      check({act_led, err_led}, 2'b01);
      rdchk(`OFF_STATUS, 32'h5);
      sup_f <= 1'b0;
      otemp <= 1'b1;
      settle();
      check(err_led, 1'b1);
      otemp <= 1'b0;
      wr(`OFF_CONTROL, 32'h3);
      connected <= 1'b0;
      settle();
      check(err_led, 1'b1);
      connected <= 1'b1;
      settle();
      check(err_led, 1'b0);
      // Toggle commands
      wr(`OFF_CONTROL, 32'h1);
      wr(`OFF_COMMAND, 32'h10);
      wr(`OFF_COMMAND, 32'h20);
      settle();
      check({cl_led, ol_led, p_led, v_led}, 4'b1010);
      rdchk(`OFF_CONTROL, 32'h7);
      // Gauge zero in open loop, then position readout
      wr(`OFF_CONTROL, 32'h5);
      wr(`OFF_SETPOINT, 32'h100);
      settle();
      // Zero is reissued here as after any power-up
      wr(`OFF_COMMAND, 32'h4);
      settle();
      rdchk(`OFF_READOUT, 32'h0);
      wr(`OFF_SETPOINT, 32'h200);
      settle();
      rdchk(`OFF_READOUT, 32'h10);
      // Force reading: gauge 0x60, offset 0x5e, factor 30
      wr(`OFF_CONTROL, 32'h15);
      wr(`OFF_FORCE, 32'h005e001e);
      settle();
      rdchk(`OFF_READOUT, 32'h3c);
      // Identify runs for a bounded time
      wr(`OFF_COMMAND, 32'h8);
      apb(1'b0, `OFF_STATUS, 32'h0);
      check(rd[3], 1'b1);
      repeat (80) @(posedge mclk);
      apb(1'b0, `OFF_STATUS, 32'h0);
      check({rd[3], id_led}, 2'b00);
      // Unmapped address is refused
      wr(12'h020, 32'hffffffff);
      check(err, 1'b1);
      apb(1'b0, 12'h020, 32'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
      rdchk(`OFF_COMMAND, 32'h0);
      report_and_stop();
   end
endmodule // test_piezo_channel_control
